/* hw/cuart_pkg.sv */
// package: register map, field layout and timing constants of the card uart status block
package cuart_pkg;
	localparam logic [3:0] ADDR_TIMEOUT_CONFIG = 4'h8;
	localparam logic [3:0] ADDR_TIMEOUT_LOW    = 4'h9;
	localparam logic [3:0] ADDR_TIMEOUT_MID    = 4'hA;
	localparam logic [3:0] ADDR_TIMEOUT_HIGH   = 4'hB;
	localparam logic [3:0] ADDR_STATUS_CONTROL = 4'hC;
	localparam logic [3:0] ADDR_HOLDING        = 4'hD;

	localparam int BIT_CLOCK_SOURCE  = 7;
	localparam int BIT_FIFO_EMPTY    = 6;
	localparam int BIT_BLOCK_GUARD   = 5;
	localparam int BIT_CONTROL_READY = 4;
	localparam int BIT_CARD_B        = 3;
	localparam int BIT_CARD_A        = 2;
	localparam int BIT_AUX_IRQ       = 1;
	localparam int BIT_BUFFER_EVENT  = 0;

	localparam int FLD_RETRY_LSB     = 4;
	localparam int BIT_THRESHOLD_EN1 = 3;
	localparam int FLD_LENGTH_LSB    = 0;

	localparam logic [7:0] TIMEOUT_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [2:0] LENGTH_RESET  = 3'h7;
	localparam logic [7:0] SPLIT_16_8_MODE = 8'h01;

	localparam int CONTROL_READY_BUSY_CYCLES = 3;
	localparam int GUARD_ETU_T0     = 16;
	localparam int GUARD_ETU_T1     = 22;
	localparam int RETRY_ETU        = 15;
	localparam int FIFO_DEPTH_MAX   = 8;

	typedef struct packed {
		logic       clock_source_flag;
		logic       fifo_empty_flag;
		logic       block_guard_flag;
		logic       control_ready;
		logic       card_b_present;
		logic       card_a_present;
		logic       aux_irq_level;
		logic       buffer_event_flag;
	} cuart_status_t;

	typedef struct packed {
		logic [2:0] parity_retry_limit;
		logic       fifo_threshold_enable_1;
		logic [2:0] fifo_length_field;
	} cuart_fifo_ctl_t;

	typedef struct packed {
		logic       start_bit;
		logic       char_sent;
		logic       char_nak;
		logic       rx_char_done;
		logic       rx_parity_bad;
		logic       etu_tick;
		logic       frac_tick;
	} cuart_events_t;
endpackage

/* hw/cuart_timeout_counter.sv */
// file: one loadable down counter of etu ticks used for the timeout chain
`timescale 1ns/10ps
module cuart_timeout_counter #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_clock,
	input  wire logic             i_nrst,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_value,
	input  wire logic             i_tick,
	output logic                  o_terminal
);
	logic [WIDTH-1:0] count;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			count <= '0;
		end else if (i_load) begin
			count <= i_value;
		end else if (i_tick && count != '0) begin
			count <= count - 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_terminal <= 1'b0;
		end else begin
			o_terminal <= i_tick && count == {{(WIDTH-1){1'b0}}, 1'b1} && !i_load;
		end
	end
endmodule

/* hw/cuart_status_fifo_timeout.sv */
// file: status, receive fifo control, parity retry and timeout counters of the card uart
// Summary of operation
// - timeout registers form one 24-bit counter or separate 16-bit and 8-bit counters
// - timeout counters advance only while the card clock is active
// - low is 8-bit or 24-bit low byte; mid and high make upper parts
// - timeout registers are write-only, zero at power-up, kept through uart reset
// - clock source flag is 1 for internal oscillator, 0 for crystal clock
// - fifo empty flag is 1 exactly when the receive fifo holds nothing
// - block guard flag clears on start bit, sets at 16 or 22 etu
// - control ready low 3 cycles after holding read or write strobe
// - control ready low one to two prescaler fractions after timeout config write
// - busy timing only in asynchronous mode; synchronous mode holds ready at 1
// - live bits show card b presence, card a presence, aux interrupt pin level
// - buffer event sets on receive-to-transmit, character sent, or fifo full
// - no buffer event when the last character is sent with last-char flag set
// - buffer event clears on reset, tx write, fifo read, or transmit-to-receive
// - t=0 nak retransmits up to retry limit at 15 etu; then parity error
// - zero retry limit: no auto retry; host rewrite allowed after 13.5 etu
// - t=0 receive sets parity error after retry limit plus one errors
// - a correctly received character resets the parity error counter
// - t=1 sets parity error on every bad received character
// - fifo threshold active only when both enables are 1; enables read 0
// - receive fifo depth is the length field plus one
// - timeout config register selects the counting mode of all three counters
`timescale 1ns/10ps
module cuart_status_fifo_timeout #(
	parameter int FIFO_DEPTH = cuart_pkg::FIFO_DEPTH_MAX
) (
	input  wire logic                     i_clock,
	input  wire logic                     i_nrst,
	input  wire logic                     i_uart_reset_n,
	input  wire logic [3:0]               i_addr,
	input  wire logic [7:0]               i_wdata,
	input  wire logic                     i_wr_n,
	input  wire logic                     i_rd_n,
	input  wire logic                     i_cs_n,
	input  wire logic                     i_card_clock_active,
	input  wire logic                     i_internal_osc_sel,
	input  wire logic                     i_card_b_present,
	input  wire logic                     i_card_a_present,
	input  wire logic                     i_aux_irq_pin,
	input  wire logic                     i_sync_mode,
	input  wire logic                     i_protocol_t1,
	input  wire logic                     i_tx_mode,
	input  wire logic                     i_last_char_flag,
	input  wire logic                     i_fifo_threshold_enable_0,
	input  wire logic                     i_prescaler_select,
	input  wire logic [3:0]               i_fifo_count,
	input  wire cuart_pkg::cuart_events_t i_events,
	output logic [7:0]                    o_rdata,
	output logic [7:0]                    o_timeout_config,
	output logic [2:0]                    o_fifo_depth_minus1,
	output logic                          o_fifo_threshold_active,
	output logic                          o_fifo_full,
	output logic                          o_retransmit,
	output logic                          o_parity_error_set,
	output logic [2:0]                    o_timeout_hit
);
	import cuart_pkg::*;

	// ************************************************
	// pin synchronisers and strobe edges
	// ************************************************
	logic [1:0] wr_sync, rd_sync, cs_sync;
	logic [1:0] card_b_sync, card_a_sync, aux_sync, clkact_sync;
	logic       wr_q, rd_q, cs_q;
	logic [3:0] addr_hold;
	logic [7:0] wdata_hold;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_sync     <= 2'h3;
			rd_sync     <= 2'h3;
			cs_sync     <= 2'h3;
			card_b_sync <= 2'h0;
			card_a_sync <= 2'h0;
			aux_sync    <= 2'h0;
			clkact_sync <= 2'h0;
			wr_q        <= 1'b1;
			rd_q        <= 1'b1;
			cs_q        <= 1'b1;
		end else begin
			wr_sync     <= {wr_sync[0], i_wr_n};
			rd_sync     <= {rd_sync[0], i_rd_n};
			cs_sync     <= {cs_sync[0], i_cs_n};
			card_b_sync <= {card_b_sync[0], i_card_b_present};
			card_a_sync <= {card_a_sync[0], i_card_a_present};
			aux_sync    <= {aux_sync[0], i_aux_irq_pin};
			clkact_sync <= {clkact_sync[0], i_card_clock_active};
			wr_q        <= wr_sync[1];
			rd_q        <= rd_sync[1];
			cs_q        <= cs_sync[1];
		end
	end

	// capture address and data while the synced strobe is low
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			addr_hold  <= 4'h0;
			wdata_hold <= 8'h00;
		end else if (!cs_sync[1] && (!wr_sync[1] || !rd_sync[1])) begin
			addr_hold  <= i_addr;
			wdata_hold <= i_wdata;
		end
	end

	// an access ends on the rising edge of wr/rd or of cs, whichever comes first
	logic cs_rise, wr_end, rd_end;
	assign cs_rise = cs_sync[1] && !cs_q;
	assign wr_end  = (wr_sync[1] && !wr_q && !cs_q) || (cs_rise && !wr_q);
	assign rd_end  = (rd_sync[1] && !rd_q && !cs_q) || (cs_rise && !rd_q);

	logic wr_timeout_cfg, wr_low, wr_mid, wr_high, wr_ctl, wr_holding, rd_holding;
	assign wr_timeout_cfg = wr_end && addr_hold == ADDR_TIMEOUT_CONFIG && i_uart_reset_n;
	assign wr_low         = wr_end && addr_hold == ADDR_TIMEOUT_LOW;
	assign wr_mid         = wr_end && addr_hold == ADDR_TIMEOUT_MID;
	assign wr_high        = wr_end && addr_hold == ADDR_TIMEOUT_HIGH;
	assign wr_ctl         = wr_end && addr_hold == ADDR_STATUS_CONTROL;
	assign wr_holding     = wr_end && addr_hold == ADDR_HOLDING;
	assign rd_holding     = rd_end && addr_hold == ADDR_HOLDING;

	// ************************************************
	// timeout registers and counters
	// ************************************************
	logic [7:0] timeout_count_low, timeout_count_mid, timeout_count_high;

	// only the power-up reset clears these; uart reset leaves them alone
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			timeout_count_low  <= TIMEOUT_RESET;
			timeout_count_mid  <= TIMEOUT_RESET;
			timeout_count_high <= TIMEOUT_RESET;
		end else begin
			if (wr_low) timeout_count_low <= wdata_hold;
			if (wr_mid) timeout_count_mid <= wdata_hold;
			if (wr_high) timeout_count_high <= wdata_hold;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_timeout_config <= TIMEOUT_RESET;
		end else if (!i_uart_reset_n) begin
			o_timeout_config <= TIMEOUT_RESET;
		end else if (wr_timeout_cfg) begin
			o_timeout_config <= wdata_hold;
		end
	end

	logic split_mode, tick_run, load_cfg, hit8, hit16, hit24;
	assign split_mode = o_timeout_config == SPLIT_16_8_MODE;
	assign tick_run   = i_events.etu_tick && clkact_sync[1];
	assign load_cfg   = wr_timeout_cfg;

	// one 24-bit chain or a 16-bit pair plus an 8-bit low counter
	cuart_timeout_counter #(.WIDTH(24)) u_count24 (
		.i_clock    (i_clock),
		.i_nrst     (i_nrst),
		.i_load     (load_cfg),
		.i_value    ({timeout_count_high, timeout_count_mid, timeout_count_low}),
		.i_tick     (tick_run && !split_mode),
		.o_terminal (hit24)
	);
	cuart_timeout_counter #(.WIDTH(16)) u_count16 (
		.i_clock    (i_clock),
		.i_nrst     (i_nrst),
		.i_load     (load_cfg),
		.i_value    ({timeout_count_high, timeout_count_mid}),
		.i_tick     (tick_run && split_mode),
		.o_terminal (hit16)
	);
	cuart_timeout_counter #(.WIDTH(8)) u_count8 (
		.i_clock    (i_clock),
		.i_nrst     (i_nrst),
		.i_load     (load_cfg),
		.i_value    (timeout_count_low),
		.i_tick     (tick_run && split_mode),
		.o_terminal (hit8)
	);
	assign o_timeout_hit = {hit24, hit16, hit8};

	// ************************************************
	// fifo and parity control register
	// ************************************************
	cuart_fifo_ctl_t fifo_ctl;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			fifo_ctl <= '{parity_retry_limit: 3'h0, fifo_threshold_enable_1: 1'b0,
				fifo_length_field: LENGTH_RESET};
		end else if (!i_uart_reset_n) begin
			fifo_ctl.fifo_threshold_enable_1 <= 1'b0;
		end else if (wr_ctl) begin
			fifo_ctl.parity_retry_limit      <= wdata_hold[FLD_RETRY_LSB +: 3];
			fifo_ctl.fifo_threshold_enable_1 <= wdata_hold[BIT_THRESHOLD_EN1];
			fifo_ctl.fifo_length_field       <= wdata_hold[FLD_LENGTH_LSB +: 3];
		end
	end

	assign o_fifo_depth_minus1 = fifo_ctl.fifo_length_field;
	assign o_fifo_threshold_active = fifo_ctl.fifo_threshold_enable_1
		&& i_fifo_threshold_enable_0;
	assign o_fifo_full = i_fifo_count == ({1'b0, fifo_ctl.fifo_length_field} + 4'h1);

	// ************************************************
	// parity error counting and retransmission
	// ************************************************
	logic [2:0] parity_count;
	logic [2:0] retry_count;
	logic [4:0] retry_etu;
	logic       retry_wait;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			parity_count       <= 3'h0;
			o_parity_error_set <= 1'b0;
		end else if (!i_uart_reset_n) begin
			parity_count       <= 3'h0;
			o_parity_error_set <= 1'b0;
		end else begin
			o_parity_error_set <= 1'b0;
			if (i_events.rx_char_done && !i_tx_mode) begin
				if (!i_events.rx_parity_bad) begin
					parity_count <= 3'h0;
				end else if (i_protocol_t1) begin
					o_parity_error_set <= 1'b1;
				end else if (parity_count == fifo_ctl.parity_retry_limit) begin
					parity_count       <= 3'h0;
					o_parity_error_set <= 1'b1;
				end else begin
					parity_count <= parity_count + 3'h1;
				end
			end
			if (i_events.char_nak && i_tx_mode && !i_protocol_t1
				&& retry_count == fifo_ctl.parity_retry_limit) begin
				o_parity_error_set <= 1'b1;
			end
		end
	end

	// retries are timed from the start bit of the nak'd character
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			retry_count  <= 3'h0;
			retry_etu    <= 5'h00;
			retry_wait   <= 1'b0;
			o_retransmit <= 1'b0;
		end else if (!i_uart_reset_n || !i_tx_mode || i_protocol_t1) begin
			retry_count  <= 3'h0;
			retry_wait   <= 1'b0;
			o_retransmit <= 1'b0;
		end else begin
			o_retransmit <= 1'b0;
			if (i_events.start_bit) begin
				retry_etu <= 5'h00;
			end else if (i_events.etu_tick && retry_etu != 5'h1F) begin
				retry_etu <= retry_etu + 5'h01;
			end
			if (i_events.char_sent) begin
				retry_count <= 3'h0;
			end else if (i_events.char_nak) begin
				// a zero limit never retries: the host rewrites instead
				retry_wait <= retry_count != fifo_ctl.parity_retry_limit;
				if (retry_count == fifo_ctl.parity_retry_limit) retry_count <= 3'h0;
			end else if (retry_wait && retry_etu == 5'(RETRY_ETU)) begin
				retry_wait   <= 1'b0;
				retry_count  <= retry_count + 3'h1;
				o_retransmit <= 1'b1;
			end
		end
	end

	// ************************************************
	// block guard timer
	// ************************************************
	logic [4:0] guard_etu;
	logic       block_guard_flag;
	logic [4:0] guard_terminal;
	assign guard_terminal = i_protocol_t1 ? 5'(GUARD_ETU_T1) : 5'(GUARD_ETU_T0);

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			guard_etu        <= 5'h00;
			block_guard_flag <= 1'b0;
		end else if (i_events.start_bit) begin
			guard_etu        <= 5'h00;
			block_guard_flag <= 1'b0;
		end else if (!block_guard_flag && i_events.etu_tick) begin
			guard_etu <= guard_etu + 5'h01;
			if (guard_etu + 5'h01 == guard_terminal) block_guard_flag <= 1'b1;
		end
	end

	// ************************************************
	// control ready busy timing
	// ************************************************
	logic [1:0] busy_cycles;
	logic [1:0] busy_fracs;
	logic       control_ready;

	// config write waits for the next fraction tick plus one more, giving 1 to 2
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_cycles <= 2'h0;
			busy_fracs  <= 2'h0;
		end else begin
			if (wr_holding || rd_holding) begin
				busy_cycles <= 2'(CONTROL_READY_BUSY_CYCLES);
			end else if (busy_cycles != 2'h0) begin
				busy_cycles <= busy_cycles - 2'h1;
			end
			if (wr_timeout_cfg) begin
				busy_fracs <= 2'h2;
			end else if (busy_fracs != 2'h0 && i_events.frac_tick) begin
				busy_fracs <= busy_fracs - 2'h1;
			end
		end
	end

	assign control_ready = i_sync_mode
		|| (busy_cycles == 2'h0 && busy_fracs == 2'h0);

	// ************************************************
	// buffer event flag
	// ************************************************
	logic buffer_event_flag, tx_mode_q, full_q;
	logic be_set, be_clr;
	assign be_set = (i_tx_mode && !tx_mode_q)
		|| (i_events.char_sent && !i_last_char_flag)
		|| (o_fifo_full && !full_q);
	assign be_clr = (wr_holding && i_tx_mode) || (rd_holding && !i_tx_mode)
		|| (!i_tx_mode && tx_mode_q);

	// a set event in the same cycle as a clear wins; a uart reset in that cycle beats the set
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			buffer_event_flag <= 1'b0;
			tx_mode_q         <= 1'b0;
			full_q            <= 1'b0;
		end else begin
			tx_mode_q <= i_tx_mode;
			full_q    <= o_fifo_full;
			if (!i_uart_reset_n) begin
				buffer_event_flag <= 1'b0;
			end else if (be_set) begin
				buffer_event_flag <= 1'b1;
			end else if (be_clr) begin
				buffer_event_flag <= 1'b0;
			end
		end
	end

	// ************************************************
	// status read
	// ************************************************
	cuart_status_t status;
	assign status = '{
		clock_source_flag: i_internal_osc_sel,
		fifo_empty_flag:   i_fifo_count == 4'h0,
		block_guard_flag:  block_guard_flag,
		control_ready:     control_ready,
		card_b_present:    card_b_sync[1],
		card_a_present:    card_a_sync[1],
		aux_irq_level:     aux_sync[1],
		buffer_event_flag: buffer_event_flag
	};

	// write-only registers and unmapped offsets read as zero
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 8'h00;
		end else if (!rd_sync[1] && !cs_sync[1] && addr_hold == ADDR_STATUS_CONTROL) begin
			o_rdata <= status;
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule

/* testbench/cuart_status_fifo_timeout_assertions.sv */
// checker: port-level properties of the card uart status block
`timescale 1ns/10ps
module cuart_status_fifo_timeout_assertions #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic                     i_clock,
	input wire logic                     i_nrst,
	input wire logic                     i_uart_reset_n,
	input wire logic [3:0]               i_addr,
	input wire logic                     i_rd_n,
	input wire logic                     i_cs_n,
	input wire logic                     i_card_clock_active,
	input wire logic                     i_card_b_present,
	input wire logic                     i_card_a_present,
	input wire logic                     i_aux_irq_pin,
	input wire logic                     i_sync_mode,
	input wire logic                     i_protocol_t1,
	input wire logic                     i_fifo_threshold_enable_0,
	input wire logic [3:0]               i_fifo_count,
	input wire cuart_pkg::cuart_events_t i_events,
	input wire logic [7:0]               o_rdata,
	input wire logic [7:0]               o_timeout_config,
	input wire logic [2:0]               o_fifo_depth_minus1,
	input wire logic                     o_fifo_threshold_active,
	input wire logic                     o_fifo_full,
	input wire logic                     o_retransmit,
	input wire logic                     o_parity_error_set,
	input wire logic [2:0]               o_timeout_hit
);
	import cuart_pkg::*;
	logic rd_c;
	assign rd_c = !i_cs_n && !i_rd_n && (i_addr == ADDR_STATUS_CONTROL);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	// ************************************************
	// status reads and card clock stops held past the pin synchronisers
	// ************************************************
	sequence ready_sync_read;
		(rd_c && i_sync_mode)[*6];
	endsequence
	sequence empty_read;
		(rd_c && $stable(i_fifo_count))[*6];
	endsequence
	sequence pins_read;
		(rd_c && $stable({i_card_b_present, i_card_a_present, i_aux_irq_pin}))[*6];
	endsequence
	sequence clock_stopped;
		(!i_card_clock_active)[*6];
	endsequence
	full_flag_a: assert property (o_fifo_full == (i_fifo_count == 4'(o_fifo_depth_minus1) + 4'h1))
		else $error("fifo full flag disagrees with depth");
	thresh_gate_a: assert property (o_fifo_threshold_active |-> i_fifo_threshold_enable_0)
		else $error("threshold active with an enable low");
	t1_parity_a: assert property (i_events.rx_parity_bad && i_protocol_t1 && i_uart_reset_n |=> o_parity_error_set)
		else $error("bad parity under t1 not flagged");
	retry_tick_a: assert property (o_retransmit |-> $past(i_events.etu_tick, 2) && !$past(i_protocol_t1))
		else $error("retransmit off the etu grid");
	clock_gate_a: assert property (clock_stopped |-> o_timeout_hit == 3'h0)
		else $error("timeout hit with card clock stopped");
	wide_mode_a: assert property (o_timeout_hit[2] |-> o_timeout_config != SPLIT_16_8_MODE)
		else $error("24-bit hit in split mode");
	split_mode_a: assert property (|o_timeout_hit[1:0] |-> o_timeout_config == SPLIT_16_8_MODE)
		else $error("split hit in 24-bit mode");
	ready_sync_a: assert property (ready_sync_read |-> o_rdata[BIT_CONTROL_READY])
		else $error("control ready low in synchronous mode");
	empty_flag_a: assert property (empty_read |-> o_rdata[BIT_FIFO_EMPTY] == (i_fifo_count == 4'h0))
		else $error("fifo empty flag wrong");
	pins_live_a: assert property (pins_read |-> o_rdata[3:1] == {i_card_b_present, i_card_a_present, i_aux_irq_pin})
		else $error("presence or aux bits wrong");
endmodule
bind cuart_status_fifo_timeout cuart_status_fifo_timeout_assertions #(.FIFO_DEPTH(FIFO_DEPTH))
	u_cuart_status_fifo_timeout_assertions (.*);

/* testbench/cuart_card_model.sv */
// card-side model: etu timing and character events seen by the status block
`timescale 1ns/10ps
module cuart_card_model #(
	parameter int ETU_CYCLES = 8
) (
	input  wire logic                i_clock,
	input  wire logic                i_nrst,
	input  wire logic                i_clock_run,
	input  wire logic                i_go,
	input  wire logic [1:0]          i_kind,
	output cuart_pkg::cuart_events_t o_events
);
	import cuart_pkg::*;
	logic [7:0] div;
	logic [3:0] etus;
	logic       busy;
	logic       start;
	logic       done;
	logic       etu;
	// ticks stop with the card clock, so no etu passes while it is parked
	assign etu = i_clock_run && (div == 8'(ETU_CYCLES - 1));
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			div <= 8'h00;
		end else begin
			div <= (etu || !i_clock_run) ? 8'h00 : div + 8'h01;
		end
	end
	// ************************************************
	// frame: start bit, then the verdict ten etu later
	// ************************************************
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			{busy, start, done, etus} <= 7'h00;
		end else begin
			start <= i_go;
			done <= busy && etu && (etus == 4'h9);
			if (i_go) begin
				busy <= 1'b1;
				etus <= 4'h0;
			end else if (busy && etu) begin
				busy <= (etus != 4'h9);
				etus <= etus + 4'h1;
			end
		end
	end
	// kind 3 naks every attempt, the worst a card may do
	assign o_events = '{start, done && (i_kind == 2'h2), done && (i_kind == 2'h3),
		done && !i_kind[1], done && (i_kind == 2'h1), etu, i_clock_run && (div[1:0] == 2'h3)};
endmodule

/* testbench/cuart_status_fifo_timeout_test.sv */
// testbench: register-level scenarios for the card uart status block
`timescale 1ns/10ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module cuart_status_fifo_timeout_test;
	import cuart_pkg::*;
	localparam int ETU = 8;
	logic       i_clock, i_nrst, i_uart_reset_n, i_wr_n, i_rd_n, i_cs_n, i_card_clock_active;
	logic       i_internal_osc_sel, i_card_b_present, i_card_a_present, i_aux_irq_pin;
	logic       i_sync_mode, i_protocol_t1, i_tx_mode, i_last_char_flag, i_fifo_threshold_enable_0;
	logic [3:0] i_addr, i_fifo_count;
	logic [7:0] i_wdata, o_rdata, o_timeout_config, q;
	logic [2:0] o_fifo_depth_minus1, o_timeout_hit;
	logic       o_fifo_threshold_active, o_fifo_full, o_retransmit, o_parity_error_set, go;
	logic [1:0] kind;
	cuart_events_t i_events;
	int n_mismatch = 0, samples_checked = 0, n_pe = 0, n_rt = 0, n_etu = 0, n_hit = 0;
	int rt_etu = 0, pe0, rt0, e0, h0;
	int hit_etu[3] = '{0, 0, 0};
	cuart_status_fifo_timeout u_cuart_status_fifo_timeout (.*, .i_prescaler_select(1'b0));
	cuart_card_model #(.ETU_CYCLES(ETU)) u_cuart_card_model (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_clock_run(i_card_clock_active), .i_go(go || o_retransmit), .i_kind(kind),
		.o_events(i_events));
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// pulse tallies; scenarios compare differences against snapshots
	always @(posedge i_clock) begin
		n_pe <= n_pe + int'(o_parity_error_set);
		n_rt <= n_rt + int'(o_retransmit);
		n_hit <= n_hit + int'(|o_timeout_hit);
		if (i_events.etu_tick) n_etu <= n_etu + 1;
		if (o_retransmit && n_rt == 0) rt_etu <= n_etu;
		for (int k = 0; k < 3; k++) if (o_timeout_hit[k]) hit_etu[k] <= n_etu;
	end
	// ************************************************
	// bus cycles: strobes held long past the synchroniser delay
	// ************************************************
	task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic rd);
		i_addr <= a;
		i_wdata <= d;
		i_cs_n <= 1'b0;
		i_rd_n <= !rd;
		i_wr_n <= rd;
		repeat (8) @(posedge i_clock);
		q = o_rdata;
		{i_cs_n, i_rd_n, i_wr_n} <= 3'h7;
		repeat (10) @(posedge i_clock);
	endtask
	task automatic chr(input logic [1:0] k, input int n);
		kind <= k;
		go <= 1'b1;
		@(posedge i_clock);
		go <= 1'b0;
		repeat (n * ETU) @(posedge i_clock);
	endtask
	task automatic bev(input logic e);
		bus(ADDR_STATUS_CONTROL, 8'h00, 1'b1);
		`CHECK(q[BIT_BUFFER_EVENT], e)
	endtask
	task automatic uart_reset;
		i_uart_reset_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_uart_reset_n <= 1'b1;
		repeat (3) @(posedge i_clock);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{i_nrst, i_uart_reset_n, i_card_clock_active, i_cs_n, i_rd_n, i_wr_n, go} = 7'h3E;
		{i_internal_osc_sel, i_card_b_present, i_card_a_present, i_aux_irq_pin} = 4'h0;
		{i_sync_mode, i_protocol_t1, i_tx_mode, i_last_char_flag, i_fifo_threshold_enable_0} = 5'h00;
		{i_addr, i_fifo_count, i_wdata, kind} = 18'h00000;
		repeat (16) @(posedge i_clock);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_clock);
		`CHECK(o_fifo_depth_minus1, 3'h7)
		`CHECK(o_timeout_config, 8'h00)
		for (int i = 0; i < 4; i++) begin
			i_internal_osc_sel <= i[0];
			i_card_b_present <= i[1];
			i_card_a_present <= !i[0];
			i_aux_irq_pin <= i[1] ^ i[0];
			i_fifo_count <= i[1] ? 4'h3 : 4'h0;
			i_sync_mode <= i[0];
			bus(ADDR_STATUS_CONTROL, 8'h00, 1'b1);
			`CHECK(q[BIT_CLOCK_SOURCE], i[0])
			`CHECK(q[BIT_FIFO_EMPTY], !i[1])
			`CHECK(q[BIT_CONTROL_READY], 1'b1)
			`CHECK(q[3:1], {i[1], !i[0], i[1] ^ i[0]})
		end
		{i_sync_mode, i_fifo_count} <= 5'h00;
		bus(ADDR_STATUS_CONTROL, 8'h09, 1'b0);
		`CHECK(o_fifo_depth_minus1, 3'h1)
		{i_fifo_count, i_fifo_threshold_enable_0} <= 5'h05;
		repeat (2) @(posedge i_clock);
		`CHECK(o_fifo_full, 1'b1)
		`CHECK(o_fifo_threshold_active, 1'b1)
		bev(1'b1);
		{i_fifo_count, i_fifo_threshold_enable_0} <= 5'h02;
		bus(ADDR_HOLDING, 8'h00, 1'b1);
		bev(1'b0);
		`CHECK(o_fifo_threshold_active, 1'b0)
		i_tx_mode <= 1'b1;
		bev(1'b1);
		bus(ADDR_HOLDING, 8'h55, 1'b0);
		bev(1'b0);
		chr(2'h2, 12);
		bev(1'b1);
		i_tx_mode <= 1'b0;
		bev(1'b0);
		{i_tx_mode, i_last_char_flag} <= 2'h3;
		bus(ADDR_HOLDING, 8'h66, 1'b0);
		chr(2'h2, 12);
		bev(1'b0);
		{i_tx_mode, i_last_char_flag} <= 2'h0;
		for (int t = 0; t < 2; t++) begin
			i_protocol_t1 <= t[0];
			chr(2'h0, (t == 1 ? GUARD_ETU_T1 : GUARD_ETU_T0) - 3);
			bus(ADDR_STATUS_CONTROL, 8'h00, 1'b1);
			`CHECK(q[BIT_BLOCK_GUARD], 1'b0)
			repeat (4 * ETU) @(posedge i_clock);
			bus(ADDR_STATUS_CONTROL, 8'h00, 1'b1);
			`CHECK(q[BIT_BLOCK_GUARD], 1'b1)
		end
		pe0 = n_pe;
		repeat (2) chr(2'h1, 12);
		`CHECK(n_pe - pe0, 2)
		i_protocol_t1 <= 1'b0;
		bus(ADDR_STATUS_CONTROL, 8'h21, 1'b0);
		pe0 = n_pe;
		for (int i = 0; i < 5; i++) chr((i == 2) ? 2'h0 : 2'h1, 12);
		`CHECK(n_pe - pe0, 0)
		chr(2'h1, 12);
		`CHECK(n_pe - pe0, 1)
		uart_reset();
		bus(ADDR_STATUS_CONTROL, 8'h21, 1'b0);
		i_tx_mode <= 1'b1;
		{pe0, rt0, e0} = {n_pe, n_rt, n_etu};
		chr(2'h3, 60);
		`CHECK(n_rt - rt0, 2)
		`CHECK(n_pe - pe0, 1)
		`CHECK(rt_etu - e0 inside {RETRY_ETU, RETRY_ETU + 1}, 1'b1)
		bus(ADDR_STATUS_CONTROL, 8'h01, 1'b0);
		{pe0, rt0} = {n_pe, n_rt};
		chr(2'h3, 40);
		`CHECK(n_rt - rt0, 0)
		`CHECK(n_pe - pe0, 1)
		i_tx_mode <= 1'b0;
		bus(ADDR_TIMEOUT_LOW, 8'h03, 1'b0);
		bus(ADDR_TIMEOUT_MID, 8'h02, 1'b0);
		bus(ADDR_TIMEOUT_HIGH, 8'h00, 1'b0);
		i_card_clock_active <= 1'b0;
		bus(ADDR_TIMEOUT_CONFIG, SPLIT_16_8_MODE, 1'b0);
		h0 = n_hit;
		repeat (300) @(posedge i_clock);
		`CHECK(n_hit - h0, 0)
		bus(ADDR_STATUS_CONTROL, 8'h00, 1'b1);
		`CHECK(q[BIT_CONTROL_READY], 1'b0)
		e0 = n_etu;
		i_card_clock_active <= 1'b1;
		repeat (6 * ETU) @(posedge i_clock);
		`CHECK(hit_etu[0] - e0 inside {3, 4}, 1'b1)
		`CHECK(hit_etu[1] - e0 inside {2, 3}, 1'b1)
		uart_reset();
		e0 = n_etu;
		bus(ADDR_TIMEOUT_CONFIG, 8'h00, 1'b0);
		repeat (530 * ETU) @(posedge i_clock);
		`CHECK(hit_etu[2] - e0 >= 515 && hit_etu[2] - e0 <= 517, 1'b1)
		end_of_test();
	end
endmodule
